// ---- shared/spsf_pkg.sv ----
// Package with register map, field positions and carrier types of the block.
package spsf_pkg;
  // Register byte offsets.
  localparam logic [7:0] STATUS_ONE_OFS = 8'h04;
  localparam logic [7:0] DATA_LOW_OFS = 8'h07;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam logic [7:0] DATA_LOW_WORD_OFS = 8'h1C;
  // Status bit positions.
  localparam int TX_BUFFER_EMPTY_FLAG_BIT = 7;
  localparam int TC_BIT = 6;
  localparam int RX_BUFFER_FULL_FLAG_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int OVR_BIT = 3;
  localparam int NF_BIT = 2;
  localparam int FE_BIT = 1;
  localparam int PF_BIT = 0;
  // Control bit positions.
  localparam int CTL_TXIE_BIT = 7;
  localparam int CTL_RXIE_BIT = 5;
  localparam int CTL_NINE_BIT = 4;
  localparam int CTL_PEN_BIT = 3;
  localparam int CTL_PKIND_BIT = 2;
  localparam int CTL_WAKE_BIT = 1;
  // Reset values.
  localparam logic [7:0] STATUS_RST = 8'hC0;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  // Idle line bit counts.
  localparam logic [3:0] IDLE_BITS_EIGHT = 4'hA;
  localparam logic [3:0] IDLE_BITS_NINE = 4'hB;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Received frame as handed over by the receive shifter.
  typedef struct packed {
    logic [8:0] data;
    logic noise;
    logic stop_bit;
    logic parity_bit;
  } spsf_rx_frame_t;

  // Transmitter activity indications.
  typedef struct packed {
    logic shift_load;
    logic busy;
    logic queued;
  } spsf_tx_state_t;
endpackage

// ---- rtl/spsf_status.sv ----
// Status flag logic of a serial port with an AXI4-Lite register slave.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
module spsf_status (
  // Clock, reset and enable.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Serial pins.
  input wire logic rx_pin_i,
  output logic tx_pin_o,
  // Receive shifter side.
  input wire logic rx_bit_tick_i,
  input wire logic rx_frame_done_i,
  input wire spsf_pkg::spsf_rx_frame_t rx_frame_i,
  output logic rx_blocked_o,
  output logic [8:0] rx_data_o,
  // Transmit shifter side.
  input wire spsf_pkg::spsf_tx_state_t tx_state_i,
  input wire logic tx_serial_i,
  output logic tx_data_write_o,
  output logic [7:0] tx_data_o,
  // Interrupt requests and wakeup clear.
  input wire logic wake_clear_i,
  output logic rx_irq_o,
  output logic tx_irq_o
);

  logic [7:0] status_reg, status_next;
  logic [7:0] armed_reg, armed_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [8:0] rxd_reg, rxd_next;
  logic [7:0] txd_reg, txd_next;
  logic [3:0] ones_reg, ones_next;
  logic idle_arm_reg, idle_arm_next;
  logic [2:0] rx_sync_reg, rx_sync_next;
  logic rx_level_reg, rx_level_next;
  logic txw_reg, txw_next;
  logic aw_hold_reg, aw_hold_next;
  logic w_hold_reg, w_hold_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  logic do_wr, do_rd;
  logic st_rd, dl_rd, dl_wr, ctl_wr;
  logic frame_ok, par_calc;
  logic [3:0] idle_need;

  // Channel handshakes: a write waits for both halves, a read for rvalid to clear.
  assign s_axi_awready_o = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready_o = ~w_hold_reg & ~bvalid_reg;
  assign s_axi_arready_o = ~rvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  // Write executes once address and data are both held or arriving.
  always_comb begin
    logic [7:0] a;
    a = aw_hold_reg ? awa_reg : s_axi_awaddr_i;
    do_wr = (aw_hold_reg | (s_axi_awvalid_i & s_axi_awready_o)) &
            (w_hold_reg | (s_axi_wvalid_i & s_axi_wready_o)) & clk_en_i;
    do_rd = s_axi_arvalid_i & s_axi_arready_o & clk_en_i;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    if (s_axi_awvalid_i & s_axi_awready_o) begin
      awa_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i & s_axi_wready_o) begin
      wd_next = s_axi_wdata_i;
      ws_next = s_axi_wstrb_i;
    end
    dl_wr = do_wr & (a[7:2] == spsf_pkg::DATA_LOW_WORD_OFS[7:2]) &
            (w_hold_reg ? ws_reg[0] : s_axi_wstrb_i[0]);
    ctl_wr = do_wr & (a[7:2] == spsf_pkg::CONTROL_OFS[7:2]) &
             (w_hold_reg ? ws_reg[0] : s_axi_wstrb_i[0]);
    st_rd = do_rd & (s_axi_araddr_i[7:2] == spsf_pkg::STATUS_ONE_OFS[7:2]);
    dl_rd = do_rd &
            (s_axi_araddr_i[7:2] == spsf_pkg::DATA_LOW_WORD_OFS[7:2]);
  end

  // Bus channel state and responses.
  always_comb begin
    logic [7:0] a;
    logic hit;
    hit = 1'b0;
    a = aw_hold_reg ? awa_reg : s_axi_awaddr_i;
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (do_wr) begin
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      // Status writes are answered but change nothing.
      hit = (a[7:2] == spsf_pkg::STATUS_ONE_OFS[7:2]) |
            (a[7:2] == spsf_pkg::DATA_LOW_WORD_OFS[7:2]) |
            (a[7:2] == spsf_pkg::CONTROL_OFS[7:2]);
      bresp_next = hit ? spsf_pkg::RESP_OKAY : spsf_pkg::RESP_SLVERR;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_hold_next = 1'b1;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_hold_next = 1'b1;
      end
    end
    if (bvalid_reg & s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    if (rvalid_reg & s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (do_rd) begin
      rvalid_next = 1'b1;
      rresp_next = spsf_pkg::RESP_OKAY;
      case (s_axi_araddr_i[7:2])
        spsf_pkg::STATUS_ONE_OFS[7:2]: rdata_next = {24'h000000, status_reg};
        spsf_pkg::DATA_LOW_WORD_OFS[7:2]: rdata_next = {23'h000000, rxd_reg};
        spsf_pkg::CONTROL_OFS[7:2]: rdata_next = {24'h000000, ctl_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = spsf_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // Receive input synchroniser; a level change needs stages two and three.
  always_comb begin
    rx_sync_next = {rx_sync_reg[1:0], rx_pin_i};
    rx_level_next = rx_level_reg;
    if (rx_sync_reg[1] == rx_sync_reg[2]) begin
      rx_level_next = rx_sync_reg[2];
    end
  end

  // Flags, control, data and idle counting.
  always_comb begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    logic [7:0] ctl_w;
    ctl_w = w_hold_reg ? wd_reg[7:0] : s_axi_wdata_i[7:0];
    set_v = 8'h00;
    clr_v = 8'h00;
    armed_next = armed_reg;
    ctl_next = ctl_reg;
    rxd_next = rxd_reg;
    txd_next = txd_reg;
    txw_next = dl_wr;
    ones_next = ones_reg;
    idle_arm_next = idle_arm_reg;
    idle_need = ctl_reg[spsf_pkg::CTL_NINE_BIT] ?
                spsf_pkg::IDLE_BITS_NINE : spsf_pkg::IDLE_BITS_EIGHT;
    par_calc = ^rx_frame_i.data ^ ctl_reg[spsf_pkg::CTL_PKIND_BIT];
    frame_ok = rx_frame_done_i & ~status_reg[spsf_pkg::FE_BIT];
    // Latch seen flags at status read, used by the next data access.
    if (st_rd) begin
      armed_next = status_reg;
    end
    if (ctl_wr) begin
      ctl_next = ctl_w;
    end
    if (wake_clear_i) begin
      ctl_next[spsf_pkg::CTL_WAKE_BIT] = 1'b0;
    end
    if (dl_wr) begin
      txd_next = ctl_w;
      clr_v[spsf_pkg::TX_BUFFER_EMPTY_FLAG_BIT] = armed_reg[spsf_pkg::TX_BUFFER_EMPTY_FLAG_BIT];
      clr_v[spsf_pkg::TC_BIT] = armed_reg[spsf_pkg::TC_BIT];
      armed_next[spsf_pkg::TX_BUFFER_EMPTY_FLAG_BIT] = 1'b0;
      armed_next[spsf_pkg::TC_BIT] = 1'b0;
    end
    if (dl_rd) begin
      // Receive flags seen at the status read clear now.
      clr_v[5:0] = armed_reg[5:0];
      armed_next[5:0] = 6'h00;
    end
    if (tx_state_i.queued) begin
      clr_v[spsf_pkg::TC_BIT] = 1'b1;
    end
    if (tx_state_i.shift_load) begin
      set_v[spsf_pkg::TX_BUFFER_EMPTY_FLAG_BIT] = 1'b1;
    end
    if (status_reg[spsf_pkg::TX_BUFFER_EMPTY_FLAG_BIT] & ~tx_state_i.busy &
        ~tx_state_i.queued) begin
      set_v[spsf_pkg::TC_BIT] = 1'b1;
    end
    if (frame_ok) begin
      if (status_reg[spsf_pkg::RX_BUFFER_FULL_FLAG_BIT] & ~clr_v[spsf_pkg::RX_BUFFER_FULL_FLAG_BIT]) begin
        set_v[spsf_pkg::OVR_BIT] = 1'b1;
      end else begin
        rxd_next = rx_frame_i.data;
        set_v[spsf_pkg::RX_BUFFER_FULL_FLAG_BIT] = 1'b1;
        set_v[spsf_pkg::NF_BIT] = rx_frame_i.noise;
        set_v[spsf_pkg::FE_BIT] = ~rx_frame_i.stop_bit;
        set_v[spsf_pkg::PF_BIT] = ctl_reg[spsf_pkg::CTL_PEN_BIT] &
                                  (par_calc != rx_frame_i.parity_bit);
        idle_arm_next = 1'b1;
      end
    end
    if (rx_bit_tick_i) begin
      if (~rx_level_reg) begin
        ones_next = 4'h0;
      end else if (ones_reg != idle_need) begin
        ones_next = ones_reg + 4'h1;
      end
      if (rx_level_reg & (ones_reg == idle_need - 4'h1) & idle_arm_reg &
          ~ctl_reg[spsf_pkg::CTL_WAKE_BIT]) begin
        set_v[spsf_pkg::IDLE_BIT] = 1'b1;
        idle_arm_next = frame_ok;
      end
    end
    // Set wins over clear, except the complete flag where clear wins.
    status_next = (status_reg & ~clr_v) | set_v;
    if (clr_v[spsf_pkg::TC_BIT]) begin
      status_next[spsf_pkg::TC_BIT] = 1'b0;
    end
  end

  // Outputs toward shifters and interrupt requests.
  always_comb begin
    tx_pin_o = status_reg[spsf_pkg::TC_BIT] ? 1'b1 : tx_serial_i;
    rx_blocked_o = status_reg[spsf_pkg::FE_BIT];
    rx_data_o = rxd_reg;
    tx_data_o = txd_reg;
    tx_data_write_o = txw_reg;
    rx_irq_o = ctl_reg[spsf_pkg::CTL_RXIE_BIT] &
               (status_reg[spsf_pkg::RX_BUFFER_FULL_FLAG_BIT] |
                status_reg[spsf_pkg::OVR_BIT]);
    tx_irq_o = ctl_reg[spsf_pkg::CTL_TXIE_BIT] &
               status_reg[spsf_pkg::TX_BUFFER_EMPTY_FLAG_BIT];
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= spsf_pkg::STATUS_RST;
      armed_reg <= 8'h00;
      ctl_reg <= spsf_pkg::CONTROL_RST;
      rxd_reg <= 9'h000;
      txd_reg <= 8'h00;
      ones_reg <= 4'h0;
      idle_arm_reg <= 1'b1;
      rx_sync_reg <= 3'h7;
      rx_level_reg <= 1'b1;
      txw_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h00000000;
      ws_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= 2'h0;
    end else if (clk_en_i) begin
      status_reg <= status_next;
      armed_reg <= armed_next;
      ctl_reg <= ctl_next;
      rxd_reg <= rxd_next;
      txd_reg <= txd_next;
      ones_reg <= ones_next;
      idle_arm_reg <= idle_arm_next;
      rx_sync_reg <= rx_sync_next;
      rx_level_reg <= rx_level_next;
      txw_reg <= txw_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

endmodule

// ---- sim/spsf_chk.sv ----
// Port checker of the serial port status flag block, bound to its top.
`timescale 1ns/10ps
module spsf_chk (
  // Clock, reset and enable.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Register bus.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Serial and shifter side.
  input wire logic tx_pin_o,
  input wire logic tx_serial_i,
  input wire logic rx_frame_done_i,
  input wire logic rx_blocked_o,
  input wire logic [8:0] rx_data_o,
  input wire logic tx_data_write_o,
  input wire logic [7:0] tx_data_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Handshakes that the slave takes on this edge.
  wire wr_take = clk_en_i && s_axi_awvalid_i && s_axi_awready_o &&
    s_axi_wvalid_i && s_axi_wready_o;
  wire rd_take = clk_en_i && s_axi_arvalid_i && s_axi_arready_o;
  write_resp_a: assert property (wr_take |=> s_axi_bvalid_o)
    else $error("write pair not answered");
  write_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
  read_resp_a: assert property (rd_take |=> s_axi_rvalid_o)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
  read_refuse_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  rx_block_a: assert property (rx_blocked_o && rx_frame_done_i && clk_en_i
    |=> $stable(rx_data_o)) else $error("frame taken while blocked");
  tx_idle_a: assert property (!tx_pin_o |-> !tx_serial_i)
    else $error("serial output not idle");
  tx_load_a: assert property (wr_take &&
    s_axi_awaddr_i == spsf_pkg::DATA_LOW_WORD_OFS |=> tx_data_write_o &&
    tx_data_o == $past(s_axi_wdata_i[7:0])) else $error("byte not passed");
  // Main scenarios.
  cover property (wr_take && s_axi_awaddr_i == spsf_pkg::DATA_LOW_WORD_OFS);
  cover property (rx_blocked_o && rx_frame_done_i);
  cover property (rd_take);
endmodule
bind spsf_status spsf_chk i_spsf_chk (.*);

// ---- sim/spsf_far.sv ----
// Remote serial device model: idle-high line with bit-time ticks.
`timescale 1ns/10ps
module spsf_far #(parameter int TICK = 8) (
  // Clock and control.
  input wire logic clk_sys_i,
  input wire logic en_i,
  input wire logic zero_i,
  // Line toward the port.
  output logic line_o = 1'b1,
  output logic tick_o = 1'b0
);
  int cnt = 0;
  // Ticks run only while the far side is active; the line idles high.
  always @(posedge clk_sys_i) begin
    cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
    tick_o <= en_i && cnt == 0;
    line_o <= !zero_i;
  end
endmodule

// ---- sim/tb_top.sv ----
// Self-checking testbench of the serial port status flag block.
`timescale 1ns/10ps
module tb_top;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, seed = 32'hAA6F68C7;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_rready_i = 1'b0, rx_frame_done_i = 1'b0;
  logic tx_serial_i = 1'b1, wake_clear_i = 1'b0;
  logic far_en = 1'b0, far_zero = 1'b0;
  spsf_pkg::spsf_rx_frame_t rx_frame_i = 12'h0;
  spsf_pkg::spsf_tx_state_t tx_state_i = 3'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, tx_pin_o, rx_blocked_o, tx_data_write_o;
  logic rx_irq_o, tx_irq_o, rx_pin_i, rx_bit_tick_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [8:0] rx_data_o;
  logic [7:0] tx_data_o;
  logic [33:0] q[$], qb[$];
  int n_mismatch = 0, checked = 0, cyc = 0;
  spsf_status i_spsf_status (.*);
  spsf_far i_spsf_far (.clk_sys_i(clk_sys_i), .en_i(far_en),
    .zero_i(far_zero), .line_o(rx_pin_i), .tick_o(rx_bit_tick_i));
  // Step of the random sequence.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Compares one result with its expectation.
  task chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task flag(input logic v, input logic e);
    chk({33'h0, v}, {33'h0, e});
  endtask
  task conclude;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Register reads and writes over the bus.
  task rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    do @(posedge clk_sys_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_sys_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    qb.push_back({spsf_pkg::RESP_OKAY, 32'h0});
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    while (!(ad && wd)) begin
      @(posedge clk_sys_i);
      if (s_axi_awvalid_i && s_axi_awready_o) ad = 1'b1;
      if (s_axi_wvalid_i && s_axi_wready_o) wd = 1'b1;
      {s_axi_awvalid_i, s_axi_wvalid_i} <= {!ad, !wd};
    end
    do @(posedge clk_sys_i); while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
  endtask
  // Shifter side stimulus.
  task fr(input logic [11:0] f);
    @(posedge clk_sys_i);
    rx_frame_i <= f;
    rx_frame_done_i <= 1'b1;
    @(posedge clk_sys_i);
    rx_frame_done_i <= 1'b0;
  endtask
  task ts(input logic [2:0] v);
    @(posedge clk_sys_i);
    tx_state_i <= v;
  endtask
  // A short low stretch with a zero-data frame with a good stop bit, then ten bit times and more.
  task gap;
    far_zero <= 1'b1;
    fr(12'h002);
    repeat (16) @(posedge clk_sys_i);
    far_zero <= 1'b0;
    repeat (150) @(posedge clk_sys_i);
  endtask
  initial forever #5 clk_sys_i = ~clk_sys_i;
  // Random serial bits, bus result monitor and hang limit.
  always @(posedge clk_sys_i) begin
    seed <= xs(seed);
    tx_serial_i <= seed[0];
    if (s_axi_rvalid_o && s_axi_rready_i)
      chk({s_axi_rresp_o, s_axi_rdata_o}, q.pop_front());
    if (s_axi_bvalid_o && s_axi_bready_i)
      chk({s_axi_bresp_o, 32'h0}, qb.pop_front());
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(8'h04, 34'(spsf_pkg::STATUS_RST));
    rd(8'h08, 34'h0);
    rd(8'h10, {spsf_pkg::RESP_SLVERR, 32'h0});
    wr(8'h04, 32'hFF);
    rd(8'h04, 34'hC0);
    wr(8'h1C, seed);
    rd(8'h04, 34'h0);
    ts(3'h6);
    ts(3'h2);
    rd(8'h04, 34'h80);
    ts(3'h0);
    rd(8'h04, 34'hC0);
    ts(3'h1);
    rd(8'h04, 34'h80);
    ts(3'h0);
    rd(8'h04, 34'hC0);
    wr(8'h08, 32'hA8);
    flag(tx_irq_o, 1'b1);
    fr(12'h00E);
    rd(8'h04, 34'hE5);
    flag(rx_irq_o, 1'b1);
    fr(12'h016);
    rd(8'h1C, 34'h1);
    chk({25'h0, rx_data_o}, 34'h1);
    rd(8'h04, 34'hC8);
    rd(8'h1C, 34'h1);
    rd(8'h04, 34'hC0);
    wr(8'h08, 32'h0C);
    fr(12'h019);
    rd(8'h04, 34'hE2);
    flag(rx_irq_o, 1'b0);
    flag(tx_irq_o, 1'b0);
    fr(12'h2AA);
    rd(8'h1C, 34'h3);
    rd(8'h04, 34'hC0);
    far_en <= 1'b1;
    repeat (150) @(posedge clk_sys_i);
    rd(8'h04, 34'hD0);
    rd(8'h1C, 34'h3);
    repeat (150) @(posedge clk_sys_i);
    rd(8'h04, 34'hC0);
    gap();
    rd(8'h04, 34'hF1);
    rd(8'h1C, 34'h0);
    wr(8'h08, 32'h02);
    gap();
    rd(8'h04, 34'hE0);
    @(posedge clk_sys_i);
    wake_clear_i <= 1'b1;
    @(posedge clk_sys_i);
    wake_clear_i <= 1'b0;
    rd(8'h08, 34'h0);
    conclude();
  end
endmodule
